/* File: logic/prma_defs.vh */
// constants for the rotor alignment sequencer
`ifndef PRMA_DEFS_VH
`define PRMA_DEFS_VH
// ======================================
// register word offsets
`define PRMA_A_CTRL    8'h00
`define PRMA_A_THRESH  8'h04
`define PRMA_A_SPEED   8'h08
`define PRMA_A_OFFSET  8'h0C
`define PRMA_A_STATUS  8'h10
`define PRMA_A_PREV    8'h14
// ======================================
// control field positions
`define PRMA_C_EN      0
`define PRMA_C_METH    1
`define PRMA_C_SEL_LO  2
`define PRMA_C_SEL_HI  3
`define PRMA_C_INC     4
`define PRMA_C_BRK     5
`define PRMA_CTRL_RST  6'h00
// start selection codes
`define PRMA_SEL_NONE  2'h0
`define PRMA_SEL_IMM   2'h1
`define PRMA_SEL_RUN   2'h2
// ======================================
// offset values, tolerance and speed ramp step
`define PRMA_OFS_FAIL  16'h7530
`define PRMA_OFS_ZERO  16'h0000
`define PRMA_TOL       16'h0040
`define PRMA_STEP      16'h0001
// ======================================
// timing, times in ms, clock in kHz
`define PRMA_CLK_KHZ   20000
`define PRMA_STAND_MS  2000
`define PRMA_SPIN_MS   4000
`define PRMA_CONT_MS   500
`define PRMA_STAND_CYC (`PRMA_STAND_MS * `PRMA_CLK_KHZ)
`define PRMA_SPIN_CYC  (`PRMA_SPIN_MS * `PRMA_CLK_KHZ)
`define PRMA_CONT_CYC  (`PRMA_CONT_MS * `PRMA_CLK_KHZ)
`endif

/* File: logic/prma_seq.v */
// rotor angle alignment sequencer for a pm motor drive
// Operation
// - first run after power-up aligns at standstill
// - release and brake lift wait for it
// - speed deviation or feedback fault: realign on next run
// - after speed deviation, new offset adopted outright
// - after power-up or feedback fault, compare with old
// - method picks spin or standstill; start needs enable, no fault
// - speed commands ignored while aligning
// - immediate start needs no controller signals
// - run-triggered spin: release with contactor, then brake
// - spin runs at 1/8 contract speed
// - spin end ramps to zero, drops release, contactor
// - spin lasts about four seconds, run indicator lit
// - run dropped during run-triggered spin: serial fault
// - speed deviation alarm holds off spin completion
// - failed alignment leaves offset at 30000
// - incremental feedback fills offset with zero
// - run-triggered standstill: contactor only, ready stays
// - standstill injects two seconds, then stores offset
// - contactor not closed when needed: contactor fault
// - standstill motion beyond threshold: motion fault
// - standstill end acts as if run were removed
// - incremental: index pulse corrects a valid alignment
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "prma_defs.vh"
module prma_seq #(
   parameter STAND_CYC = `PRMA_STAND_CYC,
   parameter SPIN_CYC  = `PRMA_SPIN_CYC,
   parameter CONT_CYC  = `PRMA_CONT_CYC
) (
   input  wire        clk_sys,
   input  wire        sys_rst,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata_q,
   input  wire        drive_enable_pin,
   input  wire        run_pin,
   input  wire        contactor_aux_pin,
   input  wire        index_pulse_pin,
   input  wire [15:0] speed_cmd,
   input  wire        speed_deviation_fault,
   input  wire        speed_deviation_alarm,
   input  wire        feedback_fault,
   input  wire        feedback_check_error,
   input  wire        overcurrent_fault,
   input  wire [15:0] motion_amount,
   input  wire [15:0] meas_angle,
   input  wire [15:0] index_angle,
   output reg         contactor_close_request_q,
   output reg         speed_regulator_release_q,
   output reg         brake_lift_output_q,
   output reg         run_ready_output_q,
   output reg         run_indicator_q,
   output reg         align_current_q,
   output reg  [15:0] speed_ref_q
);
   // ======================================
   // states
   localparam S_IDLE  = 3'h0;
   localparam S_CONT  = 3'h1;
   localparam S_SPIN  = 3'h2;
   localparam S_STAND = 3'h3;
   localparam S_RAMP  = 3'h4;
   localparam S_HOLD  = 3'h5;
   localparam S_RUN   = 3'h6;

   wire [3:0]  pins_s;
   wire        en_s;
   wire        run_s;
   wire        cont_s;
   wire        idx_s;
   reg         idx_d1_q;
   reg  [2:0]  state_q;
   reg  [26:0] tmr_q;
   reg  [5:0]  ctrl_q;
   reg  [15:0] thresh_q;
   reg  [15:0] speed_q;
   reg  [15:0] offset_q;
   reg  [15:0] prev_q;
   reg         need_q;
   reg         cmp_q;
   reg         valid_q;
   reg         onrun_q;
   reg         stand_q;
   reg         flt_cont_q;
   reg         flt_mot_q;
   reg         flt_ser_q;
   reg         flt_inc_q;
   reg  [15:0] spd_d;
   reg  [15:0] diff_d;
   reg  [15:0] res_d;

   // all pins pass two flops
   prma_sync #(.W(4)) u_sync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pin_in  ({drive_enable_pin, run_pin, contactor_aux_pin,
                 index_pulse_pin}),
      .sync_q  (pins_s)
   );
   assign en_s   = pins_s[3];
   assign run_s  = pins_s[2];
   assign cont_s = pins_s[1];
   assign idx_s  = pins_s[0];

   // ======================================
   // fault summary and permissions
   wire own_flt = flt_cont_q | flt_mot_q | flt_ser_q | flt_inc_q;
   wire ext_flt = speed_deviation_fault | feedback_fault |
                  overcurrent_fault | feedback_check_error;
   wire any_flt = own_flt | ext_flt;
   wire [1:0] sel = ctrl_q[`PRMA_C_SEL_HI:`PRMA_C_SEL_LO];
   wire permit = ctrl_q[`PRMA_C_EN] & ~any_flt;
   wire go_imm = permit & (sel == `PRMA_SEL_IMM);
   wire go_run = run_s & en_s & ~any_flt & (need_q |
                 (ctrl_q[`PRMA_C_EN] & (sel == `PRMA_SEL_RUN)));
   wire aligning = (state_q >= S_CONT) & (state_q <= S_RAMP);
   wire wr_ctrl = reg_wr & (reg_addr == `PRMA_A_CTRL);
   wire wr_stat = reg_wr & (reg_addr == `PRMA_A_STATUS);
   wire timeout = (tmr_q == 27'h0000000);

   // ======================================
   // result of a finished measurement
   always @* begin
      spd_d  = {3'h0, speed_q[15:3]};
      diff_d = (meas_angle >= prev_q) ? meas_angle - prev_q
                                      : prev_q - meas_angle;
      if (ctrl_q[`PRMA_C_INC])
         res_d = `PRMA_OFS_ZERO;
      else if (cmp_q && (diff_d > `PRMA_TOL))
         res_d = `PRMA_OFS_FAIL;
      else
         res_d = meas_angle;
   end

   // ======================================
   // software registers
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         thresh_q <= 16'hFFFF;
         speed_q  <= 16'h0000;
      end else if (reg_wr) begin
         if (reg_addr == `PRMA_A_THRESH)
            thresh_q <= reg_wdata[15:0];
         if (reg_addr == `PRMA_A_SPEED)
            speed_q <= reg_wdata[15:0];
      end
   end

   // ======================================
   // read port, data one cycle after strobe
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata_q <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PRMA_A_CTRL:   reg_rdata_q <= {26'h0, ctrl_q};
            `PRMA_A_THRESH: reg_rdata_q <= {16'h0, thresh_q};
            `PRMA_A_SPEED:  reg_rdata_q <= {16'h0, speed_q};
            `PRMA_A_OFFSET: reg_rdata_q <= {16'h0, offset_q};
            `PRMA_A_PREV:   reg_rdata_q <= {16'h0, prev_q};
            `PRMA_A_STATUS: reg_rdata_q <= {22'h0, state_q,
               onrun_q, need_q, valid_q, flt_inc_q, flt_ser_q,
               flt_mot_q, flt_cont_q};
            default:        reg_rdata_q <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_q <= 32'h00000000;
      end
   end

   // ======================================
   // alignment sequencer
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q    <= S_IDLE;
         tmr_q      <= 27'h0000000;
         ctrl_q     <= `PRMA_CTRL_RST;
         offset_q   <= `PRMA_OFS_FAIL;
         prev_q     <= `PRMA_OFS_ZERO;
         need_q     <= 1'b1;
         cmp_q      <= 1'b1;
         valid_q    <= 1'b0;
         onrun_q    <= 1'b0;
         stand_q    <= 1'b0;
         flt_cont_q <= 1'b0;
         flt_mot_q  <= 1'b0;
         flt_ser_q  <= 1'b0;
         flt_inc_q  <= 1'b0;
         idx_d1_q   <= 1'b0;
      end else begin
         idx_d1_q <= idx_s;
         if (wr_ctrl)
            ctrl_q <= reg_wdata[5:0];
         // clears first so a same-cycle set below wins
         if (wr_stat) begin
            if (reg_wdata[0]) flt_cont_q <= 1'b0;
            if (reg_wdata[1]) flt_mot_q  <= 1'b0;
            if (reg_wdata[2]) flt_ser_q  <= 1'b0;
            if (reg_wdata[3]) flt_inc_q  <= 1'b0;
         end
         if (tmr_q != 27'h0000000)
            tmr_q <= tmr_q - 27'h0000001;
         case (state_q)
            S_IDLE: begin
               if (go_imm) begin
                  // start at once, no controller handshake
                  onrun_q <= 1'b0;
                  stand_q <= ctrl_q[`PRMA_C_METH];
                  ctrl_q[`PRMA_C_SEL_HI:`PRMA_C_SEL_LO] <=
                     `PRMA_SEL_NONE;
                  tmr_q   <= CONT_CYC[26:0];
                  state_q <= S_CONT;
               end else if (go_run) begin
                  // pending realign is always standstill
                  onrun_q <= 1'b1;
                  stand_q <= need_q | ctrl_q[`PRMA_C_METH];
                  if (sel == `PRMA_SEL_RUN)
                     ctrl_q[`PRMA_C_SEL_HI:`PRMA_C_SEL_LO] <=
                        `PRMA_SEL_NONE;
                  tmr_q   <= CONT_CYC[26:0];
                  state_q <= S_CONT;
               end else if (run_s && en_s && valid_q && !any_flt) begin
                  state_q <= S_RUN;
               end else if (ctrl_q[`PRMA_C_INC] && valid_q &&
                            idx_s && !idx_d1_q) begin
                  offset_q <= index_angle;
               end
            end
            S_CONT: begin
               // contactor must report closed in time
               if (onrun_q && !run_s) begin
                  flt_ser_q <= !stand_q;
                  offset_q  <= `PRMA_OFS_FAIL;
                  valid_q   <= 1'b0;
                  state_q   <= S_IDLE;
               end else if (cont_s) begin
                  tmr_q   <= stand_q ? STAND_CYC[26:0]
                                     : SPIN_CYC[26:0];
                  state_q <= stand_q ? S_STAND : S_SPIN;
               end else if (timeout) begin
                  flt_cont_q <= 1'b1;
                  offset_q   <= `PRMA_OFS_FAIL;
                  valid_q    <= 1'b0;
                  need_q     <= 1'b1;
                  state_q    <= onrun_q ? S_HOLD : S_IDLE;
               end
            end
            S_STAND: begin
               if (!cont_s) begin
                  flt_cont_q <= 1'b1;
                  offset_q   <= `PRMA_OFS_FAIL;
                  valid_q    <= 1'b0;
                  need_q     <= 1'b1;
                  state_q    <= onrun_q ? S_HOLD : S_IDLE;
               end else if (motion_amount > thresh_q) begin
                  flt_mot_q <= 1'b1;
                  offset_q  <= `PRMA_OFS_FAIL;
                  valid_q   <= 1'b0;
                  need_q    <= 1'b1;
                  state_q   <= onrun_q ? S_HOLD : S_IDLE;
               end else if (ext_flt) begin
                  offset_q <= `PRMA_OFS_FAIL;
                  valid_q  <= 1'b0;
                  need_q   <= 1'b1;
                  state_q  <= onrun_q ? S_HOLD : S_IDLE;
               end else if (timeout) begin
                  // store, then act as if run dropped
                  offset_q <= res_d;
                  valid_q  <= (res_d != `PRMA_OFS_FAIL);
                  need_q   <= (res_d == `PRMA_OFS_FAIL);
                  if (res_d != `PRMA_OFS_FAIL)
                     prev_q <= res_d;
                  state_q  <= onrun_q ? S_HOLD : S_IDLE;
               end
            end
            S_SPIN: begin
               if (onrun_q && !run_s) begin
                  flt_ser_q <= 1'b1;
                  offset_q  <= `PRMA_OFS_FAIL;
                  valid_q   <= 1'b0;
                  need_q    <= 1'b1;
                  state_q   <= S_RAMP;
               end else if (ext_flt) begin
                  offset_q <= `PRMA_OFS_FAIL;
                  valid_q  <= 1'b0;
                  need_q   <= 1'b1;
                  state_q  <= S_RAMP;
               end else if (timeout && !speed_deviation_alarm) begin
                  // alarm keeps the spin going
                  offset_q <= res_d;
                  valid_q  <= (res_d != `PRMA_OFS_FAIL);
                  need_q   <= (res_d == `PRMA_OFS_FAIL);
                  if (res_d != `PRMA_OFS_FAIL)
                     prev_q <= res_d;
                  state_q  <= S_RAMP;
               end
            end
            S_RAMP: begin
               if (speed_ref_q == 16'h0000)
                  state_q <= onrun_q ? S_HOLD : S_IDLE;
            end
            S_HOLD: begin
               // wait for run to really drop
               if (!run_s)
                  state_q <= S_IDLE;
            end
            S_RUN: begin
               if (!run_s || !en_s || any_flt)
                  state_q <= S_IDLE;
               else if (ctrl_q[`PRMA_C_INC] && idx_s && !idx_d1_q)
                  offset_q <= index_angle;
            end
            default: state_q <= S_IDLE;
         endcase
         // fault events arm the next realignment; set wins
         if (speed_deviation_fault) begin
            need_q  <= 1'b1;
            cmp_q   <= 1'b0;
            valid_q <= 1'b0;
         end else if (feedback_fault) begin
            need_q  <= 1'b1;
            cmp_q   <= 1'b1;
            valid_q <= 1'b0;
         end
         if (ctrl_q[`PRMA_C_INC] && feedback_check_error)
            flt_inc_q <= 1'b1;
      end
   end

   // ======================================
   // output drivers, all registered
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         contactor_close_request_q <= 1'b0;
         speed_regulator_release_q <= 1'b0;
         brake_lift_output_q       <= 1'b0;
         run_ready_output_q        <= 1'b0;
         run_indicator_q           <= 1'b0;
         align_current_q           <= 1'b0;
         speed_ref_q               <= 16'h0000;
      end else begin
         run_ready_output_q <= en_s & ~any_flt;
         run_indicator_q    <= aligning | (state_q == S_RUN);
         align_current_q    <= (state_q == S_STAND) |
                               (state_q == S_SPIN);
         // standstill: contactor only; spin adds release
         contactor_close_request_q <= aligning |
                                      (state_q == S_RUN);
         speed_regulator_release_q <= (!stand_q && aligning) |
                                      (state_q == S_RUN);
         // brake lifts only after contactor closed
         brake_lift_output_q <= ctrl_q[`PRMA_C_BRK] &
            (((state_q == S_SPIN) & !stand_q) |
             ((state_q == S_RUN) & cont_s));
         case (state_q)
            S_SPIN:  speed_ref_q <= spd_d;
            S_RAMP:  speed_ref_q <= (speed_ref_q > `PRMA_STEP) ?
                        speed_ref_q - `PRMA_STEP : 16'h0000;
            S_RUN:   speed_ref_q <= speed_cmd;
            default: speed_ref_q <= 16'h0000;
         endcase
      end
   end
endmodule // prma_seq

/* File: logic/prma_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module prma_sync #(
   parameter W = 1
) (
   input  wire         clk_sys,
   input  wire         sys_rst,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] sync_q
);
   reg [W-1:0] meta_q;

   // ======================================
   // first stage feeds only the second
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end
endmodule // prma_sync

/* File: testbench/prma_car_model.sv */
// car controller and contactor model
`timescale 1ns/1ns
module prma_car_model (
   input  wire clk_sys,
   input  wire want_enable,
   input  wire want_run,
   input  wire contactor_ok,
   input  wire contactor_close_request_q,
   output reg  drive_enable_pin,
   output reg  run_pin,
   output reg  contactor_aux_pin
);
   reg [2:0] pull_q;
   initial begin
      drive_enable_pin = 1'b0;
      run_pin = 1'b0;
      contactor_aux_pin = 1'b0;
      pull_q = 3'h0;
   end
   // run follows enable
   always @(posedge clk_sys) begin
      drive_enable_pin <= want_enable;
      run_pin <= want_run & drive_enable_pin;
   end
   // contactor pulls in after four cycles
   // spin motion tolerated, speed unjudged
   always @(posedge clk_sys) begin
      pull_q <= {pull_q[1:0], contactor_close_request_q & contactor_ok};
      contactor_aux_pin <= pull_q[2];
   end
endmodule // prma_car_model

/* File: testbench/prma_seq_checker.sv */
// port assertions for the alignment sequencer
`timescale 1ns/1ns
module prma_seq_checker #(
   parameter STAND_CYC = 200,
   parameter SPIN_CYC  = 400,
   parameter CONT_CYC  = 50
) (
   input wire        clk_sys,
   input wire        sys_rst,
   input wire        reg_rd,
   input wire [31:0] reg_rdata_q,
   input wire        contactor_aux_pin,
   input wire        speed_deviation_fault,
   input wire        speed_deviation_alarm,
   input wire        feedback_fault,
   input wire        feedback_check_error,
   input wire        overcurrent_fault,
   input wire        contactor_close_request_q,
   input wire        speed_regulator_release_q,
   input wire        brake_lift_output_q,
   input wire        run_ready_output_q,
   input wire        run_indicator_q,
   input wire        align_current_q,
   input wire [15:0] speed_ref_q
);
   // ======================================
   // clocking and helpers
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   wire any_flt = speed_deviation_fault | feedback_fault |
                  feedback_check_error | overcurrent_fault;
   reg [31:0] inj_q;
   // standstill injection length
   always @(posedge clk_sys) begin
      if (sys_rst || !align_current_q || speed_regulator_release_q)
         inj_q <= 32'h0;
      else
         inj_q <= inj_q + 32'h1;
   end
   // ======================================
   // assertions
   a_fault_no_start: assert property (
      $rose(contactor_close_request_q) |->
         !$past(any_flt) && !$past(any_flt, 2) && !$past(any_flt, 3))
      else $error("start in fault");
   a_brake_after_close: assert property (
      brake_lift_output_q |->
         contactor_close_request_q && $past(contactor_aux_pin, 2))
      else $error("early brake");
   a_release_with_close: assert property (
      speed_regulator_release_q |-> contactor_close_request_q)
      else $error("release alone");
   a_stand_close_only: assert property (
      align_current_q && !speed_regulator_release_q |->
         !brake_lift_output_q && run_ready_output_q &&
         speed_ref_q == 16'h0000)
      else $error("extra output");
   a_lit_while_busy: assert property (
      align_current_q || speed_regulator_release_q |-> run_indicator_q)
      else $error("indicator dark");
   a_ramp_to_zero: assert property (
      $fell(speed_regulator_release_q) |-> speed_ref_q == 16'h0000)
      else $error("ramp cut");
   a_alarm_holds_spin: assert property (
      speed_deviation_alarm && speed_regulator_release_q &&
         speed_ref_q != 16'h0000 |=> speed_regulator_release_q)
      else $error("spin ended in alarm");
   a_rearm_gap: assert property (
      $fell(contactor_close_request_q) |->
         !contactor_close_request_q [*3])
      else $error("no re-arm");
   a_inject_span: assert property (
      inj_q <= STAND_CYC + 2)
      else $error("injection long");
   a_read_stands: assert property (
      !$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("stray read data");
   // main scenarios reached
   c_brake: cover property ($rose(brake_lift_output_q));
   c_stand: cover property ($rose(align_current_q));
   c_alarm: cover property (speed_deviation_alarm && brake_lift_output_q);
endmodule // prma_seq_checker

/* File: testbench/tb_top.sv */
// bench for the rotor alignment sequencer
`timescale 1ns/1ns
`include "prma_defs.vh"
module tb_top;
   localparam int STAND = 200;
   localparam int SPIN  = 400;
   localparam int CONT  = 50;
   reg         clk_sys = 1'b0;
   reg         sys_rst = 1'b1;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [31:0] reg_wdata = 32'h0;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg         want_enable = 1'b0;
   reg         want_run = 1'b0;
   reg         contactor_ok = 1'b1;
   reg         index_pulse_pin = 1'b0;
   reg         alarm = 1'b0;
   reg  [3:0]  flt = 4'h0;
   reg  [15:0] speed_cmd = 16'h0;
   reg  [15:0] meas_angle = 16'h0;
   reg  [15:0] index_angle = 16'h0;
   reg  [31:0] rd_q;
   wire [31:0] reg_rdata_q;
   wire [15:0] speed_ref_q;
   wire        en_pin, run_pin, aux_pin;
   wire        close_q, rel_q, brake_q, ready_q, lit_q, inj_q;
   integer     err_total = 0;
   integer     samples_checked = 0;
   always #25 clk_sys = ~clk_sys;
   // ======================================
   // design and far side
   prma_seq #(.STAND_CYC(STAND), .SPIN_CYC(SPIN), .CONT_CYC(CONT)) dut_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .drive_enable_pin(en_pin),
      .run_pin(run_pin), .contactor_aux_pin(aux_pin),
      .index_pulse_pin(index_pulse_pin), .speed_cmd(speed_cmd),
      .speed_deviation_fault(flt[0]), .speed_deviation_alarm(alarm),
      .feedback_fault(flt[1]), .feedback_check_error(flt[2]),
      .overcurrent_fault(flt[3]), .motion_amount(16'h0000),
      .meas_angle(meas_angle), .index_angle(index_angle),
      .contactor_close_request_q(close_q),
      .speed_regulator_release_q(rel_q), .brake_lift_output_q(brake_q),
      .run_ready_output_q(ready_q), .run_indicator_q(lit_q),
      .align_current_q(inj_q), .speed_ref_q(speed_ref_q));
   prma_car_model car_u (.clk_sys(clk_sys), .want_enable(want_enable),
      .want_run(want_run), .contactor_ok(contactor_ok),
      .contactor_close_request_q(close_q), .drive_enable_pin(en_pin),
      .run_pin(run_pin), .contactor_aux_pin(aux_pin));
   // ======================================
   // shared tasks
   task results;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_q = reg_rdata_q;
   endtask
   task rchk(input string what, input logic [7:0] a,
             input logic [31:0] m, input logic [31:0] exp);
      rd(a);
      chk(what, exp, rd_q & m);
   endtask
   function logic sig(input int k);
      case (k)
         0: sig = close_q;
         1: sig = rel_q;
         2: sig = brake_q;
         default: sig = inj_q;
      endcase
   endfunction
   // bounded wait; running out ends the run
   task wait_for(input int k, input logic v, input int lim);
      int n;
      n = 0;
      #1;
      while (sig(k) !== v && n < lim) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= lim) begin
         err_total++;
         $display("ERROR wait %0d expected %0b seen %0b", k, v, sig(k));
         results();
      end
   endtask
   task rerun;
      @(posedge clk_sys);
      want_run <= 1'b0;
      repeat (8) @(posedge clk_sys);
      want_run <= 1'b1;
   endtask
   // ======================================
   // scenarios
   task s_reset;
      rchk("offset", `PRMA_A_OFFSET, 32'hFFFF, 32'h7530);
      rchk("thresh", `PRMA_A_THRESH, 32'hFFFFFFFF, 32'hFFFF);
      rchk("ctrl", `PRMA_A_CTRL, 32'hFFFFFFFF, 32'h0);
      rchk("status", `PRMA_A_STATUS, 32'hFFFFFFFF, 32'h20);
      rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      rchk("prev", `PRMA_A_PREV, 32'hFFFF, 32'h0);
   endtask
   task s_power_up;
      int n;
      wr(`PRMA_A_CTRL, 32'h29);
      want_enable <= 1'b1;
      want_run <= 1'b1;
      wait_for(3, 1'b1, 60);
      chk("close", 1, close_q);
      chk("release", 0, rel_q);
      chk("brake", 0, brake_q);
      chk("ready", 1, ready_q);
      chk("lit", 1, lit_q);
      n = 0;
      while (inj_q === 1'b1 && n < 2 * STAND) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk("inject span", 1, n >= STAND - 2 && n <= STAND + 2);
      wait_for(0, 1'b0, 5);
      repeat (20) @(posedge clk_sys);
      #1 chk("held off", 0, close_q);
      rchk("kept", `PRMA_A_OFFSET, 32'hFFFF, meas_angle);
   endtask
   task s_realign_adopt;
      @(posedge clk_sys);
      flt <= 4'h1;
      meas_angle <= meas_angle + 16'h1000;
      repeat (20) @(posedge clk_sys);
      #1 chk("fault", 0, close_q);
      @(posedge clk_sys);
      flt <= 4'h0;
      rerun();
      wait_for(3, 1'b1, 60);
      wait_for(0, 1'b0, STAND + 20);
      rchk("adopted", `PRMA_A_OFFSET, 32'hFFFF, meas_angle);
   endtask
   task s_spin;
      wr(`PRMA_A_SPEED, 32'h0800);
      wr(`PRMA_A_CTRL, 32'h29);
      speed_cmd <= 16'h1234;
      rerun();
      wait_for(1, 1'b1, 60);
      chk("close", 1, close_q);
      wait_for(2, 1'b1, 60);
      @(posedge clk_sys);
      alarm <= 1'b1;
      repeat (SPIN + 100) @(posedge clk_sys);
      #1 chk("alarm", 1, rel_q);
      chk("spin ref", 32'h0100, speed_ref_q);
      @(posedge clk_sys);
      alarm <= 1'b0;
      wait_for(1, 1'b0, SPIN + 32'h100 + 50);
      chk("ref", 0, speed_ref_q);
      chk("close", 0, close_q);
   endtask
   task s_run_drop;
      wr(`PRMA_A_CTRL, 32'h29);
      rerun();
      wait_for(2, 1'b1, 60);
      @(posedge clk_sys);
      want_run <= 1'b0;
      wait_for(1, 1'b0, 32'h100 + 20);
      rchk("serial", `PRMA_A_STATUS, 32'h4, 32'h4);
      rchk("failed", `PRMA_A_OFFSET, 32'hFFFF, 32'h7530);
      wr(`PRMA_A_STATUS, 32'h4);
      rchk("cleared", `PRMA_A_STATUS, 32'h4, 32'h0);
   endtask
   task s_contactor;
      @(posedge clk_sys);
      contactor_ok <= 1'b0;
      rerun();
      wait_for(0, 1'b1, 60);
      wait_for(0, 1'b0, CONT + 20);
      rchk("contactor", `PRMA_A_STATUS, 32'h1, 32'h1);
      wr(`PRMA_A_STATUS, 32'h1);
      contactor_ok <= 1'b1;
   endtask
   task s_block;
      int k;
      for (k = 1; k < 4; k++) begin
         @(posedge clk_sys);
         flt <= 4'h1 << k;
         rerun();
         repeat (30) @(posedge clk_sys);
         #1 chk("refused", 0, close_q);
         @(posedge clk_sys);
         want_run <= 1'b0;
         repeat (4) @(posedge clk_sys);
         flt <= 4'h0;
      end
   endtask
   task s_immediate;
      wr(`PRMA_A_CTRL, 32'h17);
      wait_for(3, 1'b1, 30);
      wait_for(3, 1'b0, STAND + 20);
      rchk("inc zero", `PRMA_A_OFFSET, 32'hFFFF, 32'h0);
      @(posedge clk_sys);
      index_angle <= 16'h0123;
      index_pulse_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      index_pulse_pin <= 1'b0;
      rchk("index", `PRMA_A_OFFSET, 32'hFFFF, 32'h0123);
   endtask
   // ======================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      s_reset();
      s_power_up();
      s_realign_adopt();
      s_spin();
      s_run_drop();
      s_contactor();
      s_block();
      s_immediate();
      results();
   end
endmodule // tb_top
bind prma_seq prma_seq_checker #(.STAND_CYC(STAND_CYC),
   .SPIN_CYC(SPIN_CYC), .CONT_CYC(CONT_CYC)) chk_u (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q), .contactor_aux_pin(contactor_aux_pin),
   .speed_deviation_fault(speed_deviation_fault),
   .speed_deviation_alarm(speed_deviation_alarm),
   .feedback_fault(feedback_fault),
   .feedback_check_error(feedback_check_error),
   .overcurrent_fault(overcurrent_fault),
   .contactor_close_request_q(contactor_close_request_q),
   .speed_regulator_release_q(speed_regulator_release_q),
   .brake_lift_output_q(brake_lift_output_q),
   .run_ready_output_q(run_ready_output_q),
   .run_indicator_q(run_indicator_q), .align_current_q(align_current_q),
   .speed_ref_q(speed_ref_q));
